/* File: dv/mrs_src_model.sv */
`timescale 1ns/1ps
module mrs_src_model #(
	parameter int LOSC_DIV = 8
) (
	// Clock
	input wire logic clk,
	// Requests from the bench
	input wire logic pin_low_req,
	input wire logic wdt_req,
	// Reset sources and low oscillator tick
	output logic reset_pin = 1'b1,
	output logic wdt_overflow = 1'b0,
	output logic losc_tick = 1'b0
);
	int cnt = 0;

	// Pin has a pull-up, so a release always reads high
	always_ff @(posedge clk) reset_pin <= !pin_low_req;

	// Overflow copies the request one cycle later, for as many cycles as it is held
	always_ff @(posedge clk) wdt_overflow <= wdt_req;

	// Low oscillator shortened a lot to keep the run brief
	always_ff @(posedge clk) begin
		cnt <= (cnt == LOSC_DIV - 1) ? 0 : cnt + 1;
		losc_tick <= (cnt == LOSC_DIV - 1);
	end
endmodule : mrs_src_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb import mrs_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	mrs_opt_s opt;
	logic power_good = 1'b1;
	logic brown_out = 1'b0;
	logic pin_low_req = 1'b0;
	logic wdt_req = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic we = 1'b0;
	logic re = 1'b0;
	logic reset_pin, wdt_overflow, losc_tick, sys_hold, cpu_run, boot_pulse, instr_en;
	logic in_pin, rom_ok, lp;
	logic [7:0] rdata;
	logic [9:0] boot_pc;
	logic [7:0] v;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 44807;

	// Free-running bench clock
	always #4 clk = ~clk;

	mrs_src_model u_src (.clk(clk), .pin_low_req(pin_low_req), .wdt_req(wdt_req),
		.reset_pin(reset_pin), .wdt_overflow(wdt_overflow), .losc_tick(losc_tick));

	mrs_reset_sequencer #(.WARM_XTAL(20)) u_dut (.clk(clk), .rst_b(rst_b), .opt(opt),
		.power_good(power_good), .brown_out(brown_out), .wdt_overflow(wdt_overflow),
		.reset_pin(reset_pin), .low_voltage_flag_mid_in(1'b0), .low_voltage_flag_high_in(1'b0), .losc_tick(losc_tick),
		.addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .sys_hold(sys_hold),
		.cpu_run(cpu_run), .boot_pulse(boot_pulse), .boot_pc(boot_pc), .instr_en(instr_en),
		.input_only_pin_setting(in_pin), .rom_dump_allow(rom_ok), .low_power_active(lp));

	// Flag register image with quiet detectors
	function automatic logic [7:0] psf(input logic [1:0] c, input logic [2:0] alu);
		return {c, 3'h0, alu};
	endfunction : psf

	task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(nm, {2'h0, exp}, {2'h0, rdata});
	endtask : rd

	task automatic wait_run;
		int i;
		for (i = 0; i < 20000 && cpu_run !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i >= 20000) begin
			n_mismatch++;
			$display("[FAIL] cpu_run expected 1 seen %b", cpu_run);
			wrap_up();
		end
		chk("boot_pulse", 10'h001, {9'h0, boot_pulse});
		chk("boot_pc", BOOT_ADDR, boot_pc);
	endtask : wait_run

	// Cycles between two instruction enables
	task automatic period(input logic [9:0] exp);
		int i;
		int k;
		i = 0;
		k = 0;
		// Let a pulse launched under the old mode pass first
		repeat (2) @(posedge clk);
		#1;
		while (instr_en !== 1'b1 && i < 600) begin
			@(posedge clk);
			#1 i++;
		end
		do begin
			@(posedge clk);
			#1 k++;
		end while (instr_en !== 1'b1 && k < 600);
		chk("instr period", exp, 10'(k));
		if (i >= 600 || k >= 600) begin
			n_mismatch++;
			$display("[FAIL] instr_en expected pulse seen none");
			wrap_up();
		end
	endtask : period

	initial begin
		opt = '{clk_div: 3'($random(seed)), pin_is_reset: 1'b1, secure: 1'($random(seed)),
			low_power: 1'($random(seed)), osc_crystal: 1'b0};
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		wait_run();
		rd(PSF_ADDR, psf(CAUSE_PWR, ALU_RESET), "power cause");
		chk("rom dump", {9'h0, !opt.secure}, {9'h0, rom_ok});
		chk("low power", {9'h0, opt.low_power && opt.clk_div >= LP_MIN_DIV}, {9'h0, lp});
		period(10'h001 << opt.clk_div);
		$display("test power-on done");
		// Flag writes and an unmapped read
		v = 8'($random(seed));
		wr(PSF_ADDR, {CAUSE_PWR, v[5:0]});
		rd(PSF_ADDR, psf(CAUSE_PWR, v[2:0]), "alu flags");
		rd(8'h55, 8'h00, "unmapped");
		wr(MODE_ADDR, 8'h01);
		period(10'h020);
		chk("low power slow", {9'h0, opt.low_power}, {9'h0, lp});
		$display("test registers done");
		// Watchdog overflow while running slow
		@(posedge clk) wdt_req <= 1'b1;
		@(posedge clk) wdt_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("wdt hold", 10'h001, {9'h0, sys_hold});
		chk("wdt halt", 10'h000, {9'h0, cpu_run});
		wait_run();
		rd(PSF_ADDR, psf(CAUSE_WDT, ALU_RESET), "wdt cause");
		rd(MODE_ADDR, 8'h00, "mode after wdt");
		$display("test watchdog done");
		// Pin held low keeps the part in reset
		@(posedge clk) pin_low_req <= 1'b1;
		repeat (60) @(posedge clk);
		#1 chk("pin hold", 10'h001, {9'h0, sys_hold});
		chk("pin instr", 10'h000, {9'h0, instr_en});
		@(posedge clk) pin_low_req <= 1'b0;
		wait_run();
		rd(PSF_ADDR, psf(CAUSE_PIN, ALU_RESET), "pin cause");
		$display("test pin done");
		@(posedge clk) brown_out <= 1'b1;
		repeat (5) @(posedge clk);
		brown_out <= 1'b0;
		wait_run();
		rd(PSF_ADDR, psf(CAUSE_PWR, ALU_RESET), "brown cause");
		$display("test brown-out done");
		// Input setting ignores the pin
		@(posedge clk) rst_b <= 1'b0;
		opt.pin_is_reset <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		wait_run();
		chk("input pin high", 10'h001, {9'h0, in_pin});
		@(posedge clk) pin_low_req <= 1'b1;
		repeat (20) @(posedge clk);
		#1 chk("input run", 10'h001, {9'h0, cpu_run});
		chk("input pin", 10'h000, {9'h0, in_pin});
		$display("test input pin done");
		wrap_up();
	end
endmodule : tb

/* File: rtl/mrs_pkg.sv */
// Contract
// - Slow mode: instruction rate is low oscillator/4
// - Normal mode: instruction every 2^div clocks
// - Pin falling edge resets system when enabled
// - Input setting: no pin reset, plain input
// - Security option blocks program memory readout
// - Low power only below four MIPS
// - Reset on power, watchdog, brown-out, pin
// - Reset: registers init, halt, clear PC
// - After release, fetch starts at zero
// - Cause flags bits 7:6 encode reset source
// - Power-up waits for stable supply first; here a pin falling edge ends the supply wait early
// - Held in reset while pin not high
// - Sequence: init, oscillator warm-up, then run
// - Watchdog overflow triggers system reset
// - After watchdog reset, restart normal mode
// - Warm-up short for RC, long for crystal
package mrs_pkg;
	// Register map
	localparam logic [7:0] PSF_ADDR = 8'h86;
	localparam logic [7:0] MODE_ADDR = 8'h80;
	// Field positions of program_status_flags
	localparam int CAUSE_HI = 7;
	localparam int CAUSE_LO = 6;
	localparam int LVF_HIGH = 5;
	localparam int LVF_MID = 4;
	localparam logic [7:0] PSF_ALU_MASK = 8'h07;
	localparam int MODE_SLOW = 0;
	// Reset cause encodings
	localparam logic [1:0] CAUSE_WDT = 2'h0;
	localparam logic [1:0] CAUSE_PWR = 2'h2;
	localparam logic [1:0] CAUSE_PIN = 2'h3;
	// Reset values and boot address
	localparam logic [2:0] ALU_RESET = 3'h0;
	localparam logic [9:0] BOOT_ADDR = 10'h000;
	// Smallest divider code keeping the rate under four MIPS at 125 MHz
	localparam logic [2:0] LP_MIN_DIV = 3'h5;
	localparam logic [1:0] LOSC_DIV_LAST = 2'h3;
	localparam logic [6:0] DIV_FULL = 7'h7f;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int PWR_STABLE_NS = 1000;
	localparam int WARM_RC_NS = 2000;
	localparam int WARM_XTAL_NS = 64000;
	localparam int PWR_STABLE_CYC = (PWR_STABLE_NS * CLK_MHZ + 999) / 1000;
	localparam int WARM_RC_CYC = (WARM_RC_NS * CLK_MHZ + 999) / 1000;
	localparam int WARM_XTAL_CYC = (WARM_XTAL_NS * CLK_MHZ + 999) / 1000;
	// Factory code options
	typedef struct packed {
		logic [2:0] clk_div;
		logic pin_is_reset;
		logic secure;
		logic low_power;
		logic osc_crystal;
	} mrs_opt_s;
	typedef enum logic [2:0] {ST_POWER, ST_PIN, ST_INIT, ST_WARM, ST_RUN} mrs_state_e;
endpackage : mrs_pkg

/* File: rtl/mrs_reset_sequencer.sv */
`timescale 1ns/1ps
module mrs_reset_sequencer import mrs_pkg::*; #(
	parameter int WARM_XTAL = WARM_XTAL_CYC,
	parameter int CNT_W = 14
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_b,
	// Factory code options
	input wire mrs_opt_s opt,
	// Reset sources and analog status
	input wire logic power_good,
	input wire logic brown_out,
	input wire logic wdt_overflow,
	input wire logic reset_pin,
	input wire logic low_voltage_flag_mid_in,
	input wire logic low_voltage_flag_high_in,
	input wire logic losc_tick,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata,
	// Core control
	output logic sys_hold,
	output logic cpu_run,
	output logic boot_pulse,
	output logic [9:0] boot_pc,
	output logic instr_en,
	output logic input_only_pin_setting,
	output logic rom_dump_allow,
	output logic low_power_active
);
	mrs_state_e state;
	mrs_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic pin_q;
	logic pin_fall;
	logic [1:0] cause;
	logic [1:0] next_cause;
	logic set_cause;
	logic reset_low_voltage_flag_high;
	logic low_voltage_flag_high;
	logic low_voltage_flag_mid;
	logic [2:0] alu_flags;
	logic slow_mode;
	logic [6:0] norm_cnt;
	logic [1:0] losc_cnt;
	logic [6:0] div_mask;
	logic psf_wr;

	assign pin_fall = opt.pin_is_reset && pin_q && !reset_pin;
	assign psf_wr = we && addr == PSF_ADDR;
	assign div_mask = DIV_FULL >> (3'h7 - opt.clk_div);

	// Pin history for edge detection; pin is already synchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q <= 1'b1;
		end else begin
			pin_q <= reset_pin;
		end
	end

	// Sequencer: supply first, then pin, init, warm-up, run
	always_comb begin
		next_state = state;
		next_cause = cause;
		set_cause = 1'b0;
		case (state)
			ST_POWER: begin
				if (power_good && !brown_out && cnt == '0) begin
					next_state = opt.pin_is_reset ? ST_PIN : ST_INIT;
				end
			end
			ST_PIN: begin
				if (reset_pin) begin
					next_state = ST_INIT;
				end
			end
			ST_INIT: next_state = ST_WARM;
			ST_WARM: begin
				if (cnt == '0) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: ;
			default: next_state = ST_POWER;
		endcase
		// Source priority: supply loss over pin over watchdog
		if (!power_good || brown_out) begin
			next_state = ST_POWER;
			next_cause = CAUSE_PWR;
			set_cause = 1'b1;
		end else if (pin_fall || (opt.pin_is_reset && !reset_pin && state != ST_POWER)) begin
			next_state = ST_PIN;
			next_cause = CAUSE_PIN;
			set_cause = 1'b1;
		end else if (wdt_overflow && state == ST_RUN) begin
			next_state = ST_INIT;
			next_cause = CAUSE_WDT;
			set_cause = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_POWER;
		end else begin
			state <= next_state;
		end
	end

	// Shared wait counter, reloaded on each entry to a timed state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= CNT_W'(PWR_STABLE_CYC - 1);
		end else if (next_state == ST_POWER && (state != ST_POWER || !power_good || brown_out)) begin
			cnt <= CNT_W'(PWR_STABLE_CYC - 1);
		end else if (next_state == ST_WARM && state != ST_WARM) begin
			cnt <= opt.osc_crystal ? CNT_W'(WARM_XTAL - 1) : CNT_W'(WARM_RC_CYC - 1);
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	// Cause flags: not touched by init; hardware set beats a software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cause <= CAUSE_PWR;
		end else if (set_cause) begin
			cause <= next_cause;
		end else if (psf_wr) begin
			cause <= wdata[CAUSE_HI:CAUSE_LO];
		end
	end

	// Voltage flags track the detector while running, cleared in every state other than run
	assign reset_low_voltage_flag_high = state != ST_RUN;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_voltage_flag_high <= 1'b0;
			low_voltage_flag_mid <= 1'b0;
		end else if (reset_low_voltage_flag_high) begin
			low_voltage_flag_high <= 1'b0;
			low_voltage_flag_mid <= 1'b0;
		end else begin
			low_voltage_flag_high <= low_voltage_flag_high_in;
			low_voltage_flag_mid <= low_voltage_flag_mid_in;
		end
	end

	// Arithmetic flags and mode bit are system registers: init clears them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alu_flags <= ALU_RESET;
		end else if (state != ST_RUN) begin
			alu_flags <= ALU_RESET;
		end else if (psf_wr) begin
			alu_flags <= wdata[2:0];
		end
	end

	// Slow mode falls back to normal on every reset, watchdog included
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slow_mode <= 1'b0;
		end else if (state != ST_RUN) begin
			slow_mode <= 1'b0;
		end else if (we && addr == MODE_ADDR) begin
			slow_mode <= wdata[MODE_SLOW];
		end
	end

	// Read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (re && addr == PSF_ADDR) begin
			rdata <= {cause, low_voltage_flag_high, low_voltage_flag_mid, 1'b0, alu_flags};
		end else if (re && addr == MODE_ADDR) begin
			rdata <= {7'h00, slow_mode};
		end else begin
			rdata <= 8'h00;
		end
	end

	// Instruction rate dividers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			norm_cnt <= 7'h00;
			losc_cnt <= 2'h0;
			instr_en <= 1'b0;
		end else if (state != ST_RUN) begin
			norm_cnt <= 7'h00;
			losc_cnt <= 2'h0;
			instr_en <= 1'b0;
		end else if (slow_mode) begin
			norm_cnt <= 7'h00;
			if (losc_tick) begin
				losc_cnt <= losc_cnt + 1'b1;
			end
			instr_en <= losc_tick && losc_cnt == LOSC_DIV_LAST;
		end else begin
			losc_cnt <= 2'h0;
			norm_cnt <= (norm_cnt == div_mask) ? 7'h00 : norm_cnt + 1'b1;
			instr_en <= norm_cnt == div_mask;
		end
	end

	// Core control outputs, all registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_hold <= 1'b1;
			cpu_run <= 1'b0;
			boot_pulse <= 1'b0;
			boot_pc <= BOOT_ADDR;
		end else begin
			sys_hold <= next_state != ST_RUN;
			cpu_run <= next_state == ST_RUN;
			boot_pulse <= next_state == ST_RUN && state == ST_WARM;
			boot_pc <= BOOT_ADDR;
		end
	end

	// Option driven pin, security and low-power outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			input_only_pin_setting <= 1'b0;
			rom_dump_allow <= 1'b0;
			low_power_active <= 1'b0;
		end else begin
			input_only_pin_setting <= !opt.pin_is_reset && reset_pin;
			rom_dump_allow <= !opt.secure;
			// Low power is refused at rates of four MIPS or more
			low_power_active <= opt.low_power && (slow_mode || opt.clk_div >= LP_MIN_DIV);
		end
	end

	// Checks
	sequence s_wdt_hit;
		state == ST_RUN && wdt_overflow && power_good && !brown_out && !pin_fall
			&& !(opt.pin_is_reset && !reset_pin);
	endsequence
	sequence s_boot;
		state == ST_INIT ##1 state == ST_WARM;
	endsequence

	a_wdt_cause: assert property (@(posedge clk) disable iff (!rst_b)
		s_wdt_hit |=> state == ST_INIT && cause == CAUSE_WDT && sys_hold)
		else $error("watchdog overflow did not reset");
	a_boot_order: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(cpu_run) |-> $past(state) == ST_WARM)
		else $error("run entered without warm-up");
	a_init_warm: assert property (@(posedge clk) disable iff (!rst_b)
		s_boot |-> cnt == (opt.osc_crystal ? CNT_W'(WARM_XTAL - 1) : CNT_W'(WARM_RC_CYC - 1)))
		else $error("warm-up length wrong");
	a_pin_hold: assert property (@(posedge clk) disable iff (!rst_b)
		opt.pin_is_reset && !reset_pin |=> !cpu_run)
		else $error("ran with reset pin low");
	a_pin_fall: assert property (@(posedge clk) disable iff (!rst_b)
		pin_fall && power_good && !brown_out |=> cause == CAUSE_PIN && state == ST_PIN)
		else $error("pin edge missed");
	a_pin_input: assert property (@(posedge clk) disable iff (!rst_b)
		!opt.pin_is_reset && $past(!opt.pin_is_reset) && $past(rst_b) |->
			input_only_pin_setting == $past(reset_pin) && !pin_fall)
		else $error("input setting misbehaves");
	a_rom_lock: assert property (@(posedge clk) disable iff (!rst_b)
		opt.secure && $past(opt.secure) |-> !rom_dump_allow)
		else $error("secure part allows dump");
	a_lp_rate: assert property (@(posedge clk) disable iff (!rst_b)
		low_power_active |-> $past(slow_mode) || $past(opt.clk_div) >= LP_MIN_DIV)
		else $error("low power at high rate");
	a_slow_rate: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && slow_mode && !losc_tick |=> !instr_en)
		else $error("slow rate not from low oscillator");
	a_norm_rate: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && !slow_mode && norm_cnt != div_mask |=> !instr_en)
		else $error("normal divider wrong");
	a_hold_pc: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(cpu_run) |-> boot_pulse && boot_pc == BOOT_ADDR && !sys_hold)
		else $error("boot not at zero");
	a_power_wait: assert property (@(posedge clk) disable iff (!rst_b)
		!power_good |=> state == ST_POWER && cause == CAUSE_PWR)
		else $error("supply loss not handled");
	a_wdt_normal: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_INIT |=> !slow_mode)
		else $error("slow mode survived reset");
	a_cause_keep: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_INIT && !set_cause && !psf_wr |=> $stable(cause))
		else $error("init touched cause flags");

	// Register read and core control; hold and run are exact opposites
	a_cause_read: assert property (@(posedge clk) disable iff (!rst_b)
		re && addr == PSF_ADDR |=> rdata[CAUSE_HI:CAUSE_LO] == $past(cause))
		else $error("cause read wrong");
	a_cause_write: assert property (@(posedge clk) disable iff (!rst_b)
		psf_wr && !set_cause |=> cause == $past(wdata[CAUSE_HI:CAUSE_LO]))
		else $error("cause write lost");
	a_hold_excl: assert property (@(posedge clk) disable iff (!rst_b)
		sys_hold != cpu_run)
		else $error("hold and run overlap");
	a_pc_zero: assert property (@(posedge clk) disable iff (!rst_b)
		boot_pc == BOOT_ADDR)
		else $error("boot address not zero");
	a_boot_once: assert property (@(posedge clk) disable iff (!rst_b)
		boot_pulse |=> !boot_pulse)
		else $error("boot pulse too long");

	// Sequencer timing; a pin edge may cut the supply wait short
	a_supply_cause: assert property (@(posedge clk) disable iff (!rst_b)
		brown_out |=> cause == CAUSE_PWR && state == ST_POWER)
		else $error("brown-out not handled");
	a_power_first: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_POWER && cnt != '0 && !pin_fall |=> state == ST_POWER)
		else $error("left supply wait early");
	a_pin_wait: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_PIN && !reset_pin && power_good && !brown_out |=> state == ST_PIN)
		else $error("pin wait left with pin low");
	a_warm_count: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_WARM && cnt != '0 && power_good && !brown_out
			&& !(opt.pin_is_reset && !reset_pin) |=> state == ST_WARM)
		else $error("warm-up cut short");
	a_rom_open: assert property (@(posedge clk) disable iff (!rst_b)
		!opt.secure && $past(!opt.secure) && $past(rst_b) |-> rom_dump_allow)
		else $error("open part blocks dump");

	// Init clears system registers and stops the instruction rate
	a_hold_instr: assert property (@(posedge clk) disable iff (!rst_b)
		sys_hold |=> !instr_en)
		else $error("instruction during hold");
	a_lvd_clear: assert property (@(posedge clk) disable iff (!rst_b)
		state != ST_RUN |=> !low_voltage_flag_high && !low_voltage_flag_mid)
		else $error("voltage flags not cleared");
	a_alu_init: assert property (@(posedge clk) disable iff (!rst_b)
		state != ST_RUN |=> alu_flags == ALU_RESET)
		else $error("arithmetic flags not cleared");
	a_slow_tick: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && slow_mode && losc_tick && losc_cnt == LOSC_DIV_LAST |=> instr_en)
		else $error("slow instruction missed");
	a_norm_hit: assert property (@(posedge clk) disable iff (!rst_b)
		state == ST_RUN && !slow_mode && norm_cnt == div_mask |=> instr_en)
		else $error("normal instruction missed");
endmodule : mrs_reset_sequencer
